// *** adc_regs_pkg.sv ***
// Purpose: constants and types for the converter result, compare and pin-control registers
// Assumes: 32-bit Avalon-MM slave, byte addresses, one aligned word per 8-bit register
// Notes:   narrow registers sit in byte lane 0, the bits above read as zero
package adc_regs_pkg;

    // ****************************************************************
    // register offsets (byte addresses)
    // ****************************************************************
    localparam logic [4:0] OFS_RESULT_HIGH = 5'h00;
    localparam logic [4:0] OFS_RESULT_LOW  = 5'h04;
    localparam logic [4:0] OFS_CMP_HIGH    = 5'h08;
    localparam logic [4:0] OFS_CMP_LOW     = 5'h0c;
    localparam logic [4:0] OFS_CONFIG      = 5'h10;
    localparam logic [4:0] OFS_PIN_LOW     = 5'h14;
    localparam logic [4:0] OFS_PIN_MID     = 5'h18;
    localparam logic [4:0] OFS_CMP_CTRL    = 5'h1c;

    // ****************************************************************
    // reset values and field positions
    // ****************************************************************
    localparam logic [7:0] RST_CONFIG   = 8'h00;
    localparam logic [7:0] RST_CMP      = 8'h00;
    localparam logic [7:0] RST_PIN      = 8'h00;
    localparam logic [1:0] RST_CMP_CTRL = 2'h0;
    localparam int         CMP_EN_BIT   = 0;
    localparam int         CMP_GE_BIT   = 1;

    // ****************************************************************
    // field encodings
    // ****************************************************************
    localparam logic [1:0] MODE_8     = 2'h0;
    localparam logic [1:0] MODE_12    = 2'h1;
    localparam logic [1:0] MODE_10    = 2'h2;
    localparam logic [1:0] SRC_BUS    = 2'h0;
    localparam logic [1:0] SRC_HALF   = 2'h1;
    localparam logic [1:0] SRC_ALT    = 2'h2;
    localparam logic [1:0] SRC_ASYNC  = 2'h3;
    localparam logic [1:0] RESP_OKAY  = 2'h0;
    localparam logic [1:0] RESP_DECODE = 2'h3;

    // configuration register layout, bit 7 down to bit 0
    typedef struct packed {
        logic       low_power_select;
        logic [1:0] clock_divide_select;
        logic       long_sample_select;
        logic [1:0] mode;
        logic [1:0] source_clock_select;
    } cfg_t;

    // compare control held by software
    typedef struct packed {
        logic greater_equal;
        logic enable;
    } cmp_ctrl_t;

endpackage

// *** adc_result_compare_config_regs.sv ***
// Purpose: result bytes with read interlock, compare, configuration and pin-control registers
// Assumes: conversion done pulse and result arrive on core_clk; clocks and pins are async
// Notes:   converter clock leaves as a one-cycle enable tick on core_clk
//
// Our own choices: the Avalon-MM slave port and the placing of the registers.
`timescale 1ns/1ns
`default_nettype none
module adc_result_compare_config_regs
    import adc_regs_pkg::*;
#(
    parameter int PIN_COUNT = 16
) (
    input  wire logic                 core_clk,
    input  wire logic                 reset,
    input  wire logic [4:0]           address,
    input  wire logic                 read,
    input  wire logic                 write,
    input  wire logic [3:0]           byteenable,
    input  wire logic [31:0]          writedata,
    output logic      [31:0]          readdata,
    output logic      [1:0]           response,
    output logic                      waitrequest,
    input  wire logic                 conv_done,
    input  wire logic [11:0]          conv_result,
    input  wire logic                 alternate_source_clock,
    input  wire logic                 internal_async_clock,
    output logic                      converter_clock,
    output cfg_t                      config_out,
    output logic                      result_loaded,
    output logic                      result_lost,
    input  wire logic [PIN_COUNT-1:0] port_pin_in,
    output logic      [PIN_COUNT-1:0] port_pin_read,
    output logic      [PIN_COUNT-1:0] pin_output_hiz,
    output logic      [PIN_COUNT-1:0] pin_input_disable,
    output logic      [PIN_COUNT-1:0] pin_pullup_disable
);

    // ****************************************************************
    // helper functions
    // ****************************************************************

    // width mask of a result for the chosen resolution
    function automatic logic [11:0] mode_mask(input logic [1:0] m);
        case (m)
            MODE_12: mode_mask = 12'hfff;
            MODE_10: mode_mask = 12'h3ff;
            default: mode_mask = 12'h0ff;
        endcase
    endfunction

    // compare value built from both compare registers
    function automatic logic [11:0] cmp_value(input logic [1:0] m,
                                              input logic [7:0] hi,
                                              input logic [7:0] lo);
        cmp_value = {hi[3:0], lo} & mode_mask(m);
    endfunction

    // ****************************************************************
    // register state
    // ****************************************************************
    logic [7:0]           res_lo_q;
    logic [7:0]           res_hi_q;
    logic [7:0]           cmp_hi_q;
    logic [7:0]           cmp_lo_q;
    cfg_t                 cfg_q;
    cmp_ctrl_t            cmp_ctrl_q;
    logic [PIN_COUNT-1:0] pin_ctl_q;
    logic                 lock_q;
    logic                 ack_q;
    logic                 loaded_q;
    logic                 lost_q;
    logic [31:0]          rdata_q;
    logic [1:0]           resp_q;

    // ****************************************************************
    // avalon slave: one wait state, access acts when waitrequest low
    // ****************************************************************
    logic req;
    logic acc;
    logic mapped;
    logic wr_lane;
    assign req     = read | write;
    assign acc     = req & ack_q;
    assign mapped  = (address[1:0] == 2'h0) && (address <= OFS_CMP_CTRL);
    assign wr_lane = write & acc & byteenable[0];
    assign waitrequest = req & ~ack_q;
    assign readdata    = rdata_q;
    assign response    = resp_q;

    // acknowledge toggles on for one cycle per request
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            ack_q <= 1'b0;
        end else begin
            ack_q <= req & ~ack_q;
        end
    end

    // read data captured in the wait cycle, stands at the acknowledge edge
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            rdata_q <= 32'h0000_0000;
            resp_q  <= RESP_OKAY;
        end else if (req & ~ack_q) begin
            resp_q  <= mapped ? RESP_OKAY : RESP_DECODE;
            rdata_q <= 32'h0000_0000;
            if (read) begin
                case (address)
                    OFS_RESULT_HIGH: rdata_q[7:0] <= res_hi_q;
                    OFS_RESULT_LOW:  rdata_q[7:0] <= res_lo_q;
                    OFS_CMP_HIGH:    rdata_q[7:0] <= cmp_hi_q;
                    OFS_CMP_LOW:     rdata_q[7:0] <= cmp_lo_q;
                    OFS_CONFIG:      rdata_q[7:0] <= cfg_q;
                    OFS_PIN_LOW:     rdata_q[7:0] <= pin_ctl_q[7:0];
                    OFS_PIN_MID:     rdata_q[7:0] <= pin_ctl_q[15:8];
                    OFS_CMP_CTRL:    rdata_q[1:0] <= cmp_ctrl_q;
                    default:         rdata_q      <= 32'h0000_0000;
                endcase
            end
        end
    end

    // ****************************************************************
    // software-written registers
    // ****************************************************************
    cfg_t new_cfg;
    logic mode_chg;
    assign new_cfg  = cfg_t'(writedata[7:0]);
    assign mode_chg = wr_lane && (address == OFS_CONFIG) && (new_cfg.mode != cfg_q.mode);

    // configuration fields drive the converter directly
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            cfg_q <= cfg_t'(RST_CONFIG);
        end else if (wr_lane && address == OFS_CONFIG) begin
            cfg_q <= new_cfg;
        end
    end
    assign config_out = cfg_q;

    // compare value and compare control
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            cmp_hi_q   <= RST_CMP;
            cmp_lo_q   <= RST_CMP;
            cmp_ctrl_q <= cmp_ctrl_t'(RST_CMP_CTRL);
        end else if (wr_lane) begin
            if (address == OFS_CMP_HIGH) cmp_hi_q <= writedata[7:0];
            if (address == OFS_CMP_LOW)  cmp_lo_q <= writedata[7:0];
            if (address == OFS_CMP_CTRL) cmp_ctrl_q <= cmp_ctrl_t'(writedata[1:0]);
        end
    end

    // pin-control registers, one bit per channel
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            pin_ctl_q <= {PIN_COUNT{1'b0}};
        end else if (wr_lane) begin
            if (address == OFS_PIN_LOW) pin_ctl_q[7:0]  <= writedata[7:0];
            if (address == OFS_PIN_MID) pin_ctl_q[15:8] <= writedata[7:0];
        end
    end

    // ****************************************************************
    // compare and result loading
    // ****************************************************************
    logic [11:0] res_m;
    logic [11:0] cv_m;
    logic [11:0] diff;
    logic        cond;
    logic        load;
    assign res_m = conv_result & mode_mask(cfg_q.mode);
    assign cv_m  = cmp_value(cfg_q.mode, cmp_hi_q, cmp_lo_q);
    assign diff  = (res_m + ~cv_m + 12'h001) & mode_mask(cfg_q.mode);
    assign cond  = cmp_ctrl_q.greater_equal ? (res_m >= cv_m) : (res_m < cv_m);
    assign load  = conv_done & ~lock_q & (~cmp_ctrl_q.enable | cond);

    // result bytes; a mode change clears them and wins over a load
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            res_lo_q <= 8'h00;
            res_hi_q <= 8'h00;
        end else if (mode_chg) begin
            res_lo_q <= 8'h00;
            res_hi_q <= 8'h00;
        end else if (load) begin
            if (cmp_ctrl_q.enable) begin
                res_lo_q <= diff[7:0];
                res_hi_q <= {4'h0, diff[11:8]};
            end else begin
                res_lo_q <= res_m[7:0];
                res_hi_q <= {4'h0, res_m[11:8]};
            end
        end
    end

    // read interlock: high byte read locks until the low byte read
    // only 12-bit and 10-bit modes lock; reserved mode acts like 8-bit
    logic lock_mode;
    assign lock_mode = (cfg_q.mode == MODE_12) || (cfg_q.mode == MODE_10);
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            lock_q <= 1'b0;
        end else if (mode_chg) begin
            lock_q <= 1'b0;
        end else if (read & acc & (address == OFS_RESULT_LOW)) begin
            lock_q <= 1'b0;
        end else if (read & acc & (address == OFS_RESULT_HIGH) & lock_mode) begin
            lock_q <= 1'b1;
        end
    end

    // completion pulses: result stored, or result dropped by the lock
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            loaded_q <= 1'b0;
            lost_q   <= 1'b0;
        end else begin
            loaded_q <= load & ~mode_chg;
            lost_q   <= conv_done & lock_q;
        end
    end
    assign result_loaded = loaded_q;
    assign result_lost   = lost_q;

    // ****************************************************************
    // pin inputs: three stages, change taken when stages two and three agree
    // ****************************************************************
    localparam int SW = PIN_COUNT + 2;
    logic [SW-1:0] s1_q;
    logic [SW-1:0] s2_q;
    logic [SW-1:0] s3_q;
    logic [SW-1:0] filt_q;

    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            s1_q   <= {SW{1'b0}};
            s2_q   <= {SW{1'b0}};
            s3_q   <= {SW{1'b0}};
            filt_q <= {SW{1'b0}};
        end else begin
            s1_q   <= {internal_async_clock, alternate_source_clock, port_pin_in};
            s2_q   <= s1_q;
            s3_q   <= s2_q;
            filt_q <= (s2_q & s3_q) | (filt_q & (s2_q ^ s3_q));
        end
    end

    // handed-over pins read zero and lose buffers and pullup
    logic [PIN_COUNT-1:0] pin_read_q;
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            pin_read_q <= {PIN_COUNT{1'b0}};
        end else begin
            pin_read_q <= filt_q[PIN_COUNT-1:0] & ~pin_ctl_q;
        end
    end
    assign port_pin_read      = pin_read_q;
    assign pin_output_hiz     = pin_ctl_q;
    assign pin_input_disable  = pin_ctl_q;
    assign pin_pullup_disable = pin_ctl_q;

    // ****************************************************************
    // converter clock: source select then divide
    // ****************************************************************
    logic [1:0] clk_prev_q;
    logic       half_q;
    logic       src_tick;
    logic [2:0] div_cnt_q;
    logic [2:0] div_last;
    logic       conv_clk_q;

    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            clk_prev_q <= 2'h0;
            half_q     <= 1'b0;
        end else begin
            clk_prev_q <= filt_q[SW-1:SW-2];
            half_q     <= ~half_q;
        end
    end

    // one tick per rising edge of the chosen source
    always_comb begin
        case (cfg_q.source_clock_select)
            SRC_BUS:  src_tick = 1'b1;
            SRC_HALF: src_tick = half_q;
            SRC_ALT:  src_tick = filt_q[SW-2] & ~clk_prev_q[0];
            default:  src_tick = filt_q[SW-1] & ~clk_prev_q[1];
        endcase
    end

    assign div_last = 3'((4'h1 << cfg_q.clock_divide_select) - 4'h1);

    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            div_cnt_q  <= 3'h0;
            conv_clk_q <= 1'b0;
        end else begin
            conv_clk_q <= src_tick && (div_cnt_q >= div_last);
            if (src_tick) begin
                div_cnt_q <= (div_cnt_q >= div_last) ? 3'h0 : div_cnt_q + 3'h1;
            end
        end
    end
    assign converter_clock = conv_clk_q;

    // ****************************************************************
    // assertions
    // ****************************************************************
    default clocking @(posedge core_clk); endclocking
    default disable iff (reset);

    lock_blocks_a: assert property (
        conv_done && lock_q && !mode_chg |=> $stable(res_lo_q) && $stable(res_hi_q) && result_lost)
        else $error("locked result bytes changed");

    cmp_fail_hold_a: assert property (
        conv_done && cmp_ctrl_q.enable && !cond && !mode_chg |=> $stable(res_lo_q) && !result_loaded)
        else $error("failed compare altered result");

    plain_load_a: assert property (
        conv_done && !lock_q && !cmp_ctrl_q.enable && !mode_chg
        |=> res_lo_q == $past(res_m[7:0]) && result_loaded)
        else $error("low result byte not loaded");

    eight_no_lock_a: assert property (
        cfg_q.mode == MODE_8 ##1 cfg_q.mode == MODE_8 |-> !lock_q)
        else $error("interlock active in 8-bit mode");

    mode_clear_a: assert property (
        mode_chg |=> res_lo_q == 8'h00 && !lock_q)
        else $error("mode change kept old result");

    eight_diff_a: assert property (
        conv_done && !lock_q && !mode_chg && cfg_q.mode == MODE_8 && cmp_ctrl_q.enable
        && cmp_ctrl_q.greater_equal && conv_result[7:0] >= cmp_lo_q
        |=> res_lo_q == $past(conv_result[7:0]) - $past(cmp_lo_q) && res_hi_q == 8'h00)
        else $error("8-bit compare result wrong");

    high_byte_a: assert property (
        cfg_q.mode == MODE_10 ##1 cfg_q.mode == MODE_10 |-> res_hi_q[7:2] == 6'h00)
        else $error("10-bit high byte has upper bits set");

    pin_low_wr_a: assert property (
        wr_lane && address == OFS_PIN_LOW |=> pin_output_hiz[7:0] == $past(writedata[7:0]))
        else $error("pin-control low not written");

    pin_mid_wr_a: assert property (
        wr_lane && address == OFS_PIN_MID |=> pin_input_disable[15:8] == $past(writedata[7:0]))
        else $error("pin-control mid not written");

    half_clock_a: assert property (
        src_tick && cfg_q.source_clock_select == SRC_HALF ##1
        cfg_q.source_clock_select == SRC_HALF |-> !src_tick)
        else $error("half bus clock ticked twice");

    div_one_a: assert property (
        cfg_q.source_clock_select == SRC_BUS && cfg_q.clock_divide_select == 2'h0
        ##1 cfg_q.source_clock_select == SRC_BUS && cfg_q.clock_divide_select == 2'h0
        |=> converter_clock)
        else $error("undivided bus clock did not tick");

    pin_read_zero_a: assert property (
        pin_ctl_q[0] ##1 pin_ctl_q[0] |-> !port_pin_read[0])
        else $error("handed-over pin reads nonzero");

endmodule // adc_result_compare_config_regs
`default_nettype wire

// *** tb_top.sv ***
// Purpose: self-checking bench for the converter result, compare and pin registers
// Assumes: master waits for waitrequest low, result bytes read high then low
// Notes:   alternate and internal clocks toggle well below a quarter of core_clk
`timescale 1ns/1ns
`default_nettype none
`define CHK(nm, e, g) check(nm, 32'(e), 32'(g))
module tb_top;
    import adc_regs_pkg::*;
    logic        core_clk    = 1'b0;
    logic        reset       = 1'b1;
    logic [4:0]  address     = 5'h00;
    logic        read        = 1'b0;
    logic        write       = 1'b0;
    logic [3:0]  byteenable  = 4'hf;
    logic [31:0] writedata   = 32'h0;
    logic        conv_done   = 1'b0;
    logic [11:0] conv_result = 12'h000;
    logic        alt_clk     = 1'b0;
    logic        async_clk   = 1'b0;
    logic [15:0] port_pin_in = 16'hffff;
    logic [31:0] readdata, rd_data;
    logic [1:0]  response, rd_resp;
    logic        waitrequest, converter_clock, result_loaded, result_lost, loaded_s, lost_s;
    cfg_t        config_out;
    logic [15:0] port_pin_read, pin_output_hiz, pin_input_disable, pin_pullup_disable;
    int          fails = 0, cmp_count = 0, cycles = 0, ticks, exp_t[4] = '{64, 32, 8, 4};

    adc_result_compare_config_regs u_adc_result_compare_config_regs (
        .core_clk(core_clk), .reset(reset), .address(address), .read(read), .write(write),
        .byteenable(byteenable), .writedata(writedata), .readdata(readdata),
        .response(response), .waitrequest(waitrequest), .conv_done(conv_done),
        .conv_result(conv_result), .alternate_source_clock(alt_clk),
        .internal_async_clock(async_clk), .converter_clock(converter_clock),
        .config_out(config_out), .result_loaded(result_loaded), .result_lost(result_lost),
        .port_pin_in(port_pin_in), .port_pin_read(port_pin_read),
        .pin_output_hiz(pin_output_hiz), .pin_input_disable(pin_input_disable),
        .pin_pullup_disable(pin_pullup_disable));

    // ****************************************************************
    // clock, slow source clocks and run limit
    // ****************************************************************
    always #4 core_clk = ~core_clk;
    always @(posedge core_clk) begin
        cycles <= cycles + 1;
        if (cycles % 4 == 3) alt_clk <= ~alt_clk;
        if (cycles % 8 == 7) async_clk <= ~async_clk;
        if (cycles == 20000) begin
            fails = fails + 1;
            summarize();
        end
    end

    // ****************************************************************
    // helpers
    // ****************************************************************
    task automatic check(input string nm, input logic [31:0] e, input logic [31:0] g);
        cmp_count++;
        if (g !== e) begin
            fails++;
            $display("[ERR] %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic summarize();
        $display("checks %0d mismatches %0d", cmp_count, fails);
        if (fails == 0 && cmp_count > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask

    // one access: hold until waitrequest is sampled low at a rising edge, take data, release
    task automatic bus(input logic w, input logic [4:0] a, input logic [7:0] d,
                       input logic [3:0] be = 4'hf);
        @(posedge core_clk);
        address <= a;
        writedata <= {24'h0, d};
        byteenable <= be;
        write <= w;
        read <= !w;
        do @(posedge core_clk); while (waitrequest !== 1'b0);
        rd_data = readdata;
        rd_resp = response;
        write <= 1'b0;
        read <= 1'b0;
        @(negedge core_clk); // outputs settled for checks after the call
    endtask

    task automatic rd_chk(input string nm, input logic [4:0] a, input logic [7:0] e);
        bus(1'b0, a, 8'h00);
        `CHK(nm, e, rd_data);
    endtask

    task automatic res_chk(input logic [7:0] hi, input logic [7:0] lo);
        rd_chk("result_high", OFS_RESULT_HIGH, hi);
        rd_chk("result_low", OFS_RESULT_LOW, lo);
    endtask

    // one completion pulse, then the load and loss pulses are captured
    task automatic conv(input logic [11:0] r);
        @(posedge core_clk);
        conv_done <= 1'b1;
        conv_result <= r;
        @(posedge core_clk);
        conv_done <= 1'b0;
        #1;
        loaded_s = result_loaded;
        lost_s = result_lost;
    endtask

    task automatic count();
        repeat (16) @(posedge core_clk);
        ticks = 0;
        repeat (64) begin
            @(negedge core_clk);
            ticks += int'(converter_clock);
        end
    endtask

    // ****************************************************************
    // test sequence
    // ****************************************************************
    initial begin
        repeat (2) @(posedge core_clk);
        reset <= 1'b0;
        rd_chk("config", OFS_CONFIG, RST_CONFIG);
        rd_chk("cmp_high", OFS_CMP_HIGH, RST_CMP);
        rd_chk("cmp_low", OFS_CMP_LOW, RST_CMP);
        rd_chk("pin_low", OFS_PIN_LOW, RST_PIN);
        rd_chk("pin_mid", OFS_PIN_MID, RST_PIN);
        $display("test reset done");
        bus(1'b1, OFS_CONFIG, 8'hb6);
        `CHK("low_power", 1'b1, config_out.low_power_select);
        `CHK("divide", 2'h1, config_out.clock_divide_select);
        `CHK("long_sample", 1'b1, config_out.long_sample_select);
        `CHK("mode", MODE_12, config_out.mode);
        `CHK("source", SRC_ALT, config_out.source_clock_select);
        bus(1'b1, OFS_CONFIG, 8'h49, 4'he);
        rd_chk("config", OFS_CONFIG, 8'hb6);
        for (int d = 0; d < 4; d++) begin
            bus(1'b1, OFS_CONFIG, {1'b0, 2'(d), 5'h00});
            count();
            `CHK("div_ticks", 64 >> d, ticks);
        end
        for (int s = 0; s < 4; s++) begin
            bus(1'b1, OFS_CONFIG, {6'h00, 2'(s)});
            count();
            `CHK("src_ticks", 1'b1, ticks >= exp_t[s] - 1 && ticks <= exp_t[s] + 1);
        end
        $display("test config done");
        bus(1'b1, OFS_CONFIG, 8'h04);
        conv(12'h123);
        `CHK("loaded", 1'b1, loaded_s);
        res_chk(8'h01, 8'h23);
        bus(1'b1, OFS_CONFIG, 8'h08);
        conv(12'hfa5);
        res_chk(8'h03, 8'ha5);
        bus(1'b1, OFS_CONFIG, 8'h00);
        conv(12'h1c7);
        res_chk(8'h00, 8'hc7);
        bus(1'b1, OFS_CONFIG, 8'h04);
        rd_chk("cleared_low", OFS_RESULT_LOW, 8'h00);
        conv(12'h123);
        rd_chk("result_high", OFS_RESULT_HIGH, 8'h01);
        conv(12'h456);
        `CHK("lost", 1'b1, lost_s);
        rd_chk("locked_low", OFS_RESULT_LOW, 8'h23);
        conv(12'h456);
        res_chk(8'h04, 8'h56);
        bus(1'b1, OFS_CONFIG, 8'h00);
        conv(12'h0ab);
        rd_chk("result_high", OFS_RESULT_HIGH, 8'h00);
        conv(12'h0cd);
        `CHK("lost", 1'b0, lost_s);
        rd_chk("free_low", OFS_RESULT_LOW, 8'hcd);
        $display("test result done");
        bus(1'b1, OFS_CMP_HIGH, 8'h01);
        bus(1'b1, OFS_CONFIG, 8'h04);
        bus(1'b1, OFS_CMP_CTRL, 8'h03);
        conv(12'h180);
        res_chk(8'h00, 8'h80);
        conv(12'h0ff);
        `CHK("loaded", 1'b0, loaded_s);
        res_chk(8'h00, 8'h80);
        bus(1'b1, OFS_CMP_CTRL, 8'h01);
        conv(12'h0f0);
        res_chk(8'h0f, 8'hf0);
        bus(1'b1, OFS_CONFIG, 8'h08);
        bus(1'b1, OFS_CMP_HIGH, 8'h05);
        bus(1'b1, OFS_CMP_CTRL, 8'h03);
        conv(12'h180);
        res_chk(8'h00, 8'h80);
        bus(1'b1, OFS_CONFIG, 8'h00);
        bus(1'b1, OFS_CMP_LOW, 8'h10);
        conv(12'h040);
        res_chk(8'h00, 8'h30);
        conv(12'h005);
        `CHK("loaded", 1'b0, loaded_s);
        $display("test compare done");
        bus(1'b1, OFS_PIN_LOW, 8'ha5);
        bus(1'b1, OFS_PIN_MID, 8'h3c);
        `CHK("hiz", 16'h3ca5, pin_output_hiz);
        `CHK("in_dis", 16'h3ca5, pin_input_disable);
        `CHK("pull_dis", 16'h3ca5, pin_pullup_disable);
        repeat (8) @(negedge core_clk);
        `CHK("pin_read", 16'hc35a, port_pin_read);
        rd_chk("pin_mid", OFS_PIN_MID, 8'h3c);
        $display("test pins done");
        bus(1'b0, 5'h02, 8'h00);
        `CHK("bad_resp", RESP_DECODE, rd_resp);
        `CHK("bad_data", 32'h0, rd_data);
        bus(1'b1, OFS_RESULT_LOW, 8'h77);
        rd_chk("ro_low", OFS_RESULT_LOW, 8'h30);
        `CHK("ok_resp", RESP_OKAY, rd_resp);
        $display("test bus done");
        summarize();
    end
endmodule // tb_top
`default_nettype wire
